// file: include/cap_regs.vh
`ifndef CAP_REGS_VH
`define CAP_REGS_VH

// ==========================================================
// widths
`define CAP_DW 16
`define CAP_AW 5

// ==========================================================
// register word addresses
`define CAP_A_CTRL 5'h00
`define CAP_A_BMODE 5'h01
`define CAP_A_PER_B 5'h02
`define CAP_A_RISE_B 5'h03
`define CAP_A_FALL_B 5'h04
`define CAP_A_DTR_B 5'h05
`define CAP_A_DTF_B 5'h06
`define CAP_A_ADA_B 5'h07
`define CAP_A_ADB_B 5'h08
`define CAP_A_PER 5'h09
`define CAP_A_RISE 5'h0a
`define CAP_A_FALL 5'h0b
`define CAP_A_DTR 5'h0c
`define CAP_A_DTF 5'h0d
`define CAP_A_ADA 5'h0e
`define CAP_A_ADB 5'h0f
`define CAP_A_STAT 5'h10
`define CAP_A_CNT 5'h11

// ==========================================================
// control register fields
`define CAP_CTRL_RUN 0
`define CAP_CTRL_MODE4 1
`define CAP_CTRL_POL_LO 2
`define CAP_CTRL_POL_HI 3
`define CAP_CTRL_W 4

// ==========================================================
// buffer mode register fields
`define CAP_BM_PER 0
`define CAP_BM_RISE 1
`define CAP_BM_FALL 2
`define CAP_BM_DTR 3
`define CAP_BM_DTF 4
`define CAP_BM_ADA 5
`define CAP_BM_ADB 6
`define CAP_BM_ASEL_LO 7
`define CAP_BM_ASEL_HI 8
`define CAP_BM_BSEL_LO 9
`define CAP_BM_BSEL_HI 10
`define CAP_BM_W 11

// ==========================================================
// adc update select codes
`define CAP_SEL_UP 2'h0
`define CAP_SEL_DOWN 2'h1
`define CAP_SEL_BOTH 2'h2

// ==========================================================
// reset values
`define CAP_RST_CTRL 4'h0
`define CAP_RST_BMODE 11'h000
`define CAP_RST_PER 16'h00ff
`define CAP_RST_WORD 16'h0000

`endif

// file: test/cap_pwm_props.sv
`timescale 1ns/1ns
`include "cap_regs.vh"

// ==========================================================
// port level checks for the triangle pwm channel
module cap_pwm_props
(
	input wire mclk,
	input wire nrst,
	input wire [`CAP_AW-1:0] addr,
	input wire [`CAP_DW-1:0] wdata,
	input wire wr,
	input wire rd,
	input wire [`CAP_DW-1:0] rdata,
	input wire pwm_p,
	input wire pwm_n,
	input wire adc_req_a,
	input wire adc_req_b
);
	// one clock domain, so one default for all
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// two counter reads two cycles apart: at most two steps apart
	property p_cnt_step;
		$past(rd, 3) && $past(rd) && $past(addr, 3) == `CAP_A_CNT && $past(addr) == `CAP_A_CNT
		|-> (rdata - $past(rdata, 2) <= 16'h0002) || ($past(rdata, 2) - rdata <= 16'h0002);
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");

	// an edge of p is never followed by another at once
	property p_p_space;
		$changed(pwm_p) |=> $stable(pwm_p);
	endproperty
	a_p_space: assert property (p_p_space) else $error("p toggled twice");

	// same for the complement output
	property p_n_space;
		$changed(pwm_n) |=> $stable(pwm_n);
	endproperty
	a_n_space: assert property (p_n_space) else $error("n toggled twice");

	// adc requests are single cycle pulses
	property p_ada_pulse;
		adc_req_a |=> !adc_req_a;
	endproperty
	a_ada_pulse: assert property (p_ada_pulse) else $error("adc a request too long");

	property p_adb_pulse;
		adc_req_b |=> !adc_req_b;
	endproperty
	a_adb_pulse: assert property (p_adb_pulse) else $error("adc b request too long");

	// status holds only the direction bit
	property p_stat_bits;
		rd && addr == `CAP_A_STAT |=> rdata[15:1] == 15'h0000;
	endproperty
	a_stat_bits: assert property (p_stat_bits) else $error("status upper bits set");

	// read data is zero outside the answer cycle
	property p_rd_idle;
		!$past(rd) |-> rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

	// control reads only four bits
	property p_ctrl_bits;
		rd && addr == `CAP_A_CTRL |=> rdata[15:4] == 12'h000;
	endproperty
	a_ctrl_bits: assert property (p_ctrl_bits) else $error("control upper bits set");

	c_ada: cover property (adc_req_a);
	c_adb: cover property ($rose(adc_req_b));
	c_p: cover property ($rose(pwm_p));
endmodule

bind cap_pwm cap_pwm_props u_props (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .pwm_p(pwm_p), .pwm_n(pwm_n), .adc_req_a(adc_req_a), .adc_req_b(adc_req_b));

// file: test/cap_pwm_tb.sv
`timescale 1ns/1ns
`include "cap_regs.vh"
`define CAP_CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t %h %h", $time, a, b); end end

// ==========================================================
// self checking bench for the triangle pwm channel
module cap_pwm_tb;
	reg mclk = 0;
	reg nrst = 0; // active low reset
	reg wr = 0;
	reg rd = 0;
	reg rd_d = 0; // marks the answer cycle
	reg [`CAP_AW-1:0] addr = 0;
	reg [`CAP_DW-1:0] wdata = 0;
	wire [`CAP_DW-1:0] rdata;
	wire pwm_p, pwm_n, adc_req_a, adc_req_b;
	logic [15:0] expq[$]; // expected read data, oldest first
	logic [15:0] exp_d; // note taken off the queue for one answer
	int fails = 0, checks = 0, m, s, r, w, h;

	// 20 MHz clock
	always #25 mclk = ~mclk;

	cap_pwm dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pwm_p(pwm_p), .pwm_n(pwm_n), .adc_req_a(adc_req_a), .adc_req_b(adc_req_b));

	// ==========================================================
	// monitor: read data stands only in the cycle after rd
	always @(posedge mclk)
	begin
		rd_d <= rd;
		// pop once: the macro names its second argument twice
		if (rd_d)
		begin
			exp_d = expq.pop_front();
			`CAP_CHK(rdata, exp_d)
		end
	end

	// ==========================================================
	// bus tasks; a gap cycle keeps strobes from being set twice at one edge
	task wreg(input [4:0] ad, input [15:0] d);
		addr <= ad;
		wdata <= d;
		wr <= 1;
		@(posedge mclk);
		wr <= 0;
		@(posedge mclk);
	endtask

	task rreg(input [4:0] ad, input [15:0] e);
		expq.push_back(e);
		addr <= ad;
		rd <= 1;
		@(posedge mclk);
		rd <= 0;
		@(posedge mclk);
	endtask

	task do_rst;
		nrst <= 0;
		repeat (16) @(posedge mclk);
		nrst <= 1;
		@(posedge mclk);
	endtask

	task finish_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// watchdog: whole run is a few thousand cycles
	initial
	begin
		#(50 * 20000);
		fails++;
		finish_test;
	end

	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(16));
		do_rst;
		// reset values, counter, unmapped place
		for (s = 0; s < 16; s++)
			rreg(s[4:0], (s == 2 || s == 9) ? `CAP_RST_PER : 16'h0000);
		rreg(`CAP_A_CNT, 16'h0000);
		rreg(5'h1f, 16'h0000);
		// active copies are read only
		wreg(`CAP_A_PER, 16'h1234);
		rreg(`CAP_A_PER, `CAP_RST_PER);
		// sweep both triangle modes and every adc a select code
		for (m = 0; m < 2; m++)
			for (s = 0; s < 4; s++)
			begin
				do_rst;
				r = ($urandom & 31) + 8; // stays inside the period
				w = $urandom & 63;
				wreg(`CAP_A_PER_B, 16'h0040); // unbuffered: lands at once
				wreg(`CAP_A_BMODE, {7'h00, s[1:0], 7'h23});
				wreg(`CAP_A_PER_B, 16'h0030);
				wreg(`CAP_A_RISE_B, r[15:0]);
				wreg(`CAP_A_ADA_B, w[15:0]);
				wreg(`CAP_A_ADB_B, w[15:0]);
				rreg(`CAP_A_RISE, 16'h0000);
				rreg(`CAP_A_ADB, w[15:0]);
				wreg(`CAP_A_CTRL, m ? 16'h0003 : 16'h0001);
				// past the up turn, mid down slope
				repeat (92) @(posedge mclk);
				rreg(`CAP_A_RISE, m ? r[15:0] : 16'h0000);
				rreg(`CAP_A_ADA, s == 1 ? 16'h0000 : w[15:0]);
				rreg(`CAP_A_PER, 16'h0040);
				rreg(`CAP_A_STAT, 16'h0000);
				// down slope from 0x40: count stands at 27, then at 25
				expq.push_back(16'h001b);
				expq.push_back(16'h0019);
				// back to back counter reads feed the step check
				addr <= `CAP_A_CNT;
				rd <= 1;
				@(posedge mclk);
				rd <= 0;
				@(posedge mclk);
				rd <= 1;
				@(posedge mclk);
				rd <= 0;
				@(posedge mclk);
				// past the down turn, on the next up slope
				repeat (30) @(posedge mclk);
				rreg(`CAP_A_RISE, r[15:0]);
				rreg(`CAP_A_ADA, w[15:0]);
				rreg(`CAP_A_PER, 16'h0030);
				rreg(`CAP_A_STAT, 16'h0001);
				// p high for twice the distance from threshold to period
				@(posedge pwm_p);
				h = 0;
				@(negedge mclk);
				while (pwm_p === 1'b1)
				begin
					h++;
					@(negedge mclk);
				end
				`CAP_CHK(16'(h), 16'(2 * (48 - r)))
				// zero dead time: complement turns high as p falls
				`CAP_CHK({15'h0000, pwm_n}, 16'h0001)
			end
		finish_test;
	end
endmodule

// file: verilog/cap_pwm.v
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "cap_regs.vh"

// ==========================================================
// triangle pwm channel with double-buffered parameters
module cap_pwm
(
	input wire mclk,
	input wire nrst,
	input wire [`CAP_AW-1:0] addr,
	input wire [`CAP_DW-1:0] wdata,
	input wire wr,
	input wire rd,
	output reg [`CAP_DW-1:0] rdata,
	output reg pwm_p,
	output reg pwm_n,
	output reg adc_req_a,
	output reg adc_req_b
);

	// ==========================================================
	// software-visible state
	reg [`CAP_CTRL_W-1:0] timer_control_register; // run, mode, polarity
	reg [`CAP_BM_W-1:0] buffer_mode_register; // enables and adc selects
	reg [`CAP_DW-1:0] period_buffer;
	reg [`CAP_DW-1:0] base_threshold_rise_buffer;
	reg [`CAP_DW-1:0] base_threshold_fall_buffer;
	reg [`CAP_DW-1:0] dead_time_rising_buffer;
	reg [`CAP_DW-1:0] dead_time_falling_buffer;
	reg [`CAP_DW-1:0] adc_request_a_buffer;
	reg [`CAP_DW-1:0] adc_request_b_buffer;
	// active parameters; the fall threshold and falling dead time are only read back
	reg [`CAP_DW-1:0] period_value;
	reg [`CAP_DW-1:0] base_threshold_rise;
	reg [`CAP_DW-1:0] base_threshold_fall;
	reg [`CAP_DW-1:0] dead_time_rising;
	reg [`CAP_DW-1:0] dead_time_falling;
	reg [`CAP_DW-1:0] adc_request_a_compare;
	reg [`CAP_DW-1:0] adc_request_b_compare;

	// ==========================================================
	// counter
	wire [`CAP_DW-1:0] cnt; // carrier value
	wire dir_up; // high while climbing
	wire up_exp; // one-cycle turn at period
	wire down_exp; // one-cycle turn at zero

	cap_tri_cnt u_cnt
	(
		.mclk(mclk),
		.nrst(nrst),
		.run(timer_control_register[`CAP_CTRL_RUN]),
		.period(period_value),
		.cnt(cnt),
		.dir_up(dir_up),
		.up_exp(up_exp),
		.down_exp(down_exp)
	);

	// ==========================================================
	// update points
	wire mode4 = timer_control_register[`CAP_CTRL_MODE4];
	wire [1:0] adc_a_update_select = buffer_mode_register[`CAP_BM_ASEL_HI:`CAP_BM_ASEL_LO];
	wire [1:0] adc_b_update_select = buffer_mode_register[`CAP_BM_BSEL_HI:`CAP_BM_BSEL_LO];
	// period always turns over after the down-count
	wire upd_per = down_exp;
	// mode 3 waits for the down-count, mode 4 takes both halves
	wire upd_base = down_exp | (mode4 & up_exp);
	reg upd_a; // adc a update point
	reg upd_b; // adc b update point

	// adc compare update points follow their own select fields
	always @*
	begin
		case (adc_a_update_select)
			`CAP_SEL_UP: upd_a = up_exp;
			`CAP_SEL_DOWN: upd_a = down_exp;
			default: upd_a = up_exp | down_exp;
		endcase
		case (adc_b_update_select)
			`CAP_SEL_UP: upd_b = up_exp;
			`CAP_SEL_DOWN: upd_b = down_exp;
			default: upd_b = up_exp | down_exp;
		endcase
	end

	// write decode
	wire w_ctrl = wr && addr == `CAP_A_CTRL;
	wire w_bm = wr && addr == `CAP_A_BMODE;
	wire w_per = wr && addr == `CAP_A_PER_B;
	wire w_rise = wr && addr == `CAP_A_RISE_B;
	wire w_fall = wr && addr == `CAP_A_FALL_B;
	wire w_dtr = wr && addr == `CAP_A_DTR_B;
	wire w_dtf = wr && addr == `CAP_A_DTF_B;
	wire w_ada = wr && addr == `CAP_A_ADA_B;
	wire w_adb = wr && addr == `CAP_A_ADB_B;
	wire [`CAP_BM_W-1:0] en = buffer_mode_register;

	// ==========================================================
	// control and buffer registers
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			timer_control_register <= `CAP_RST_CTRL;
			buffer_mode_register <= `CAP_RST_BMODE;
			period_buffer <= `CAP_RST_PER;
			base_threshold_rise_buffer <= `CAP_RST_WORD;
			base_threshold_fall_buffer <= `CAP_RST_WORD;
			dead_time_rising_buffer <= `CAP_RST_WORD;
			dead_time_falling_buffer <= `CAP_RST_WORD;
			adc_request_a_buffer <= `CAP_RST_WORD;
			adc_request_b_buffer <= `CAP_RST_WORD;
		end
		else
		begin
			if (w_ctrl)
				timer_control_register <= wdata[`CAP_CTRL_W-1:0];
			if (w_bm)
				buffer_mode_register <= wdata[`CAP_BM_W-1:0];
			if (w_per)
				period_buffer <= wdata;
			if (w_rise)
				base_threshold_rise_buffer <= wdata;
			if (w_fall)
				base_threshold_fall_buffer <= wdata;
			if (w_dtr)
				dead_time_rising_buffer <= wdata;
			if (w_dtf)
				dead_time_falling_buffer <= wdata;
			if (w_ada)
				adc_request_a_buffer <= wdata;
			if (w_adb)
				adc_request_b_buffer <= wdata;
		end
	end

	// ==========================================================
	// active parameters: copied at update points when buffered,
	// written straight through when the buffer is disabled
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			period_value <= `CAP_RST_PER;
			base_threshold_rise <= `CAP_RST_WORD;
			base_threshold_fall <= `CAP_RST_WORD;
			dead_time_rising <= `CAP_RST_WORD;
			dead_time_falling <= `CAP_RST_WORD;
			adc_request_a_compare <= `CAP_RST_WORD;
			adc_request_b_compare <= `CAP_RST_WORD;
		end
		else
		begin
			// a buffered copy uses the buffer as it stood before this edge
			if (en[`CAP_BM_PER] ? upd_per : w_per)
				period_value <= en[`CAP_BM_PER] ? period_buffer : wdata;
			if (en[`CAP_BM_RISE] ? upd_base : w_rise)
				base_threshold_rise <= en[`CAP_BM_RISE] ? base_threshold_rise_buffer : wdata;
			if (en[`CAP_BM_FALL] ? upd_base : w_fall)
				base_threshold_fall <= en[`CAP_BM_FALL] ? base_threshold_fall_buffer : wdata;
			if (en[`CAP_BM_DTR] ? upd_base : w_dtr)
				dead_time_rising <= en[`CAP_BM_DTR] ? dead_time_rising_buffer : wdata;
			if (en[`CAP_BM_DTF] ? upd_base : w_dtf)
				dead_time_falling <= en[`CAP_BM_DTF] ? dead_time_falling_buffer : wdata;
			if (en[`CAP_BM_ADA] ? upd_a : w_ada)
				adc_request_a_compare <= en[`CAP_BM_ADA] ? adc_request_a_buffer : wdata;
			if (en[`CAP_BM_ADB] ? upd_b : w_adb)
				adc_request_b_compare <= en[`CAP_BM_ADB] ? adc_request_b_buffer : wdata;
		end
	end

	// ==========================================================
	// waveform
	// complement threshold leads the base edge by the rising dead time;
	// a dead time above the threshold clips the complement threshold to zero here
	wire [`CAP_DW-1:0] complement_threshold_rise = (dead_time_rising > base_threshold_rise) ?
		`CAP_RST_WORD : base_threshold_rise - dead_time_rising;
	wire hit_p = cnt == base_threshold_rise; // base match
	wire hit_n = cnt == complement_threshold_rise; // complement match
	wire [1:0] output_polarity_select = timer_control_register[`CAP_CTRL_POL_HI:`CAP_CTRL_POL_LO];
	reg p_raw; // base waveform before polarity
	reg n_raw; // complement waveform before polarity

	// same threshold on both slopes gives edges symmetric about the turn
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			p_raw <= 1'b0;
			n_raw <= 1'b1;
		end
		else if (timer_control_register[`CAP_CTRL_RUN])
		begin
			if (hit_p)
				p_raw <= dir_up;
			if (hit_n)
				n_raw <= ~dir_up;
		end
	end

	// ==========================================================
	// registered outputs and read port
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwm_p <= 1'b0;
			pwm_n <= 1'b0;
			adc_req_a <= 1'b0;
			adc_req_b <= 1'b0;
			rdata <= `CAP_RST_WORD;
		end
		else
		begin
			pwm_p <= p_raw ^ output_polarity_select[0];
			pwm_n <= n_raw ^ output_polarity_select[1];
			// adc requests pulse on compare match while running
			adc_req_a <= timer_control_register[`CAP_CTRL_RUN] && cnt == adc_request_a_compare;
			adc_req_b <= timer_control_register[`CAP_CTRL_RUN] && cnt == adc_request_b_compare;
			if (rd)
			begin
				case (addr)
					`CAP_A_CTRL: rdata <= {12'h000, timer_control_register};
					`CAP_A_BMODE: rdata <= {5'h00, buffer_mode_register};
					`CAP_A_PER_B: rdata <= period_buffer;
					`CAP_A_RISE_B: rdata <= base_threshold_rise_buffer;
					`CAP_A_FALL_B: rdata <= base_threshold_fall_buffer;
					`CAP_A_DTR_B: rdata <= dead_time_rising_buffer;
					`CAP_A_DTF_B: rdata <= dead_time_falling_buffer;
					`CAP_A_ADA_B: rdata <= adc_request_a_buffer;
					`CAP_A_ADB_B: rdata <= adc_request_b_buffer;
					`CAP_A_PER: rdata <= period_value;
					`CAP_A_RISE: rdata <= base_threshold_rise;
					`CAP_A_FALL: rdata <= base_threshold_fall;
					`CAP_A_DTR: rdata <= dead_time_rising;
					`CAP_A_DTF: rdata <= dead_time_falling;
					`CAP_A_ADA: rdata <= adc_request_a_compare;
					`CAP_A_ADB: rdata <= adc_request_b_compare;
					`CAP_A_STAT: rdata <= {15'h0000, dir_up};
					`CAP_A_CNT: rdata <= cnt;
					default: rdata <= `CAP_RST_WORD;
				endcase
			end
			else
				rdata <= `CAP_RST_WORD;
		end
	end

endmodule

// file: verilog/cap_tri_cnt.v
`timescale 1ns/1ns
`include "cap_regs.vh"

// ==========================================================
// up/down counter for the triangle carrier
module cap_tri_cnt
(
	input wire mclk,
	input wire nrst,
	input wire run,
	input wire [`CAP_DW-1:0] period,
	output reg [`CAP_DW-1:0] cnt,
	output reg dir_up,
	output reg up_exp,
	output reg down_exp
);

	// counter turns at period and at zero, flagging each turn for one cycle
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt <= `CAP_RST_WORD;
			dir_up <= 1'b1;
			up_exp <= 1'b0;
			down_exp <= 1'b0;
		end
		else
		begin
			up_exp <= 1'b0;
			down_exp <= 1'b0;
			// a zero period would wrap the counter, so it is held instead
			if (run && period != `CAP_RST_WORD)
			begin
				if (dir_up)
				begin
					if (cnt >= period)
					begin
						dir_up <= 1'b0;
						cnt <= cnt - 16'h0001;
						up_exp <= 1'b1;
					end
					else
						cnt <= cnt + 16'h0001;
				end
				else
				begin
					if (cnt == `CAP_RST_WORD)
					begin
						dir_up <= 1'b1;
						cnt <= cnt + 16'h0001;
						down_exp <= 1'b1;
					end
					else
						cnt <= cnt - 16'h0001;
				end
			end
		end
	end

endmodule
